/* src/isp_pkg.sv */
// Purpose: Shared constants and types of the indexer station positioner
// Assumes: 25 MHz system clock, synchronous active-high reset
// Notes: Times are kept in ms and converted to cycles with MS_CYC
//
// Notes on behaviour
// - Target station comes from next-station word
// - Speed from table entry or direct word
// - Mode enabled only with operation digit 1
// - Speed-method parameter picks word interpretation
// - Direction parameter sets station allocation sense
// - Station above count minus one warns
// - Eight entries: speed, accel, decel
// - Accel constant 0 to 20000 ms
// - Decel constant 0 to 20000 ms
// - Direct speed needs two stations, entry 1
// - Table mode start uses selected entry
// - Direct mode start uses word speed
// - Start before homing raises home alarm
// - Start ignored while a move runs
// - Torque limit switches after in-position delay
// - In-position on at power-up when in range
// - Speed selection latched at start only
package isp_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MS_CYC = CLK_HZ / 1000;

  // ---------------------------------------------------------------
  // Fields, limits and reset values
  // ---------------------------------------------------------------
  localparam int OPSEL_MSB = 15;
  localparam int OPSEL_LSB = 12;
  localparam logic [3:0] OPSEL_INDEXER = 4'h1;
  localparam int TBL_DEPTH = 8;
  localparam logic [2:0] TBL_FIRST = 3'h0;
  localparam logic [15:0] TC_MAX_MS = 16'h4E20;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_STATION = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] speed;
    logic [15:0] acc_ms;
    logic [15:0] dec_ms;
  } isp_entry_t;

  typedef struct packed {
    logic [15:0] station;
    logic [15:0] speed;
    logic [15:0] acc_ms;
    logic [15:0] dec_ms;
    logic dir;
  } isp_cmd_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_MOVE = 1'b1
  } isp_state_t;

endpackage : isp_pkg

/* src/isp_bit_sync.sv */
// Purpose: Two-flop synchroniser for a group of remote bits
// Assumes: Each bit is independent; no word coherence needed
// Notes: Only the second stage may be read by logic
module isp_bit_sync #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Bits
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  import isp_pkg::*;

  logic [W-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          meta[g] <= 1'b0;
          o_sync[g] <= 1'b0;
        end else begin
          meta[g] <= i_async[g];
          o_sync[g] <= meta[g];
        end
      end
    end
  endgenerate

endmodule : isp_bit_sync

/* src/isp_point_table.sv */
// Purpose: Eight-entry point table of speed and ramp constants
// Assumes: Written by the parameter path, read by index
// Notes: Ramp constants above the limit are clamped on write
module isp_point_table #(
  parameter int DEPTH = isp_pkg::TBL_DEPTH
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Write port
  input wire logic i_we,
  input wire logic [2:0] i_widx,
  input wire isp_pkg::isp_entry_t i_wdata,
  // Read port
  input wire logic [2:0] i_ridx,
  output isp_pkg::isp_entry_t o_rdata
);
  import isp_pkg::*;

  isp_entry_t mem [DEPTH];
  isp_entry_t wclamp;

  function automatic logic [15:0] clamp_tc(input logic [15:0] v);
    clamp_tc = (v > TC_MAX_MS) ? TC_MAX_MS : v;
  endfunction : clamp_tc

  assign wclamp.speed = i_wdata.speed;
  assign wclamp.acc_ms = clamp_tc(i_wdata.acc_ms);
  assign wclamp.dec_ms = clamp_tc(i_wdata.dec_ms);
  assign o_rdata = mem[i_ridx];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          mem[g] <= '0;
        end else if (i_we && i_widx == 3'(g)) begin
          mem[g] <= wclamp;
        end
      end
    end
  endgenerate

  chk_tc_clamp: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_we |=> mem[$past(i_widx)].acc_ms <= TC_MAX_MS
             && mem[$past(i_widx)].dec_ms <= TC_MAX_MS)
    else $error("ramp constant stored above limit");

endmodule : isp_point_table

/* src/isp_indexer.sv */
// Purpose: Start, speed selection and status of the indexer mode
// Assumes: Motion loop on the same clock executes o_cmd
// Notes: Remote bits arrive from the link and are synchronised;
//        the station word is compared every cycle for the warning; both words are latched at a start
module isp_indexer #(
  parameter int unsigned P_MS_CYC = isp_pkg::MS_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Remote bits from the master
  input wire logic i_start_bit,
  input wire logic i_mode_select_one,
  input wire logic i_mode_select_two,
  input wire logic i_spec_system_select,
  input wire logic i_rot_dir,
  input wire logic i_alarm_clear,
  // Remote words from the master
  input wire logic [15:0] i_next_station_word,
  input wire logic [15:0] i_speed_or_table_word,
  // Parameters
  input wire logic [15:0] i_operation_select_param,
  input wire logic i_speed_method_param,
  input wire logic i_station_direction_param,
  input wire logic [15:0] i_station_count_param,
  input wire logic [15:0] i_positioning_torque_limit_param,
  input wire logic [15:0] i_normal_torque_limit,
  input wire logic [15:0] i_torque_switch_delay_param,
  input wire logic i_two_stations,
  // Point table write
  input wire logic i_tbl_we,
  input wire logic [2:0] i_tbl_idx,
  input wire isp_pkg::isp_entry_t i_tbl_data,
  // Motion loop
  input wire logic i_home_done,
  input wire logic i_in_range,
  input wire logic i_move_done,
  output logic o_move_req,
  output isp_pkg::isp_cmd_t o_cmd,
  // Status to the master
  output logic o_in_position_out,
  output logic o_movement_complete_out,
  output logic [7:0] o_station_out,
  output logic o_home_incomplete_alarm,
  output logic o_next_station_warning,
  output logic o_torque_sel,
  output logic [15:0] o_torque_limit
);
  import isp_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [5:0] bits_sync;
  logic s_start;
  logic s_md1;
  logic s_md2;
  logic s_spec;
  logic s_dir;
  logic s_aclr;

  isp_bit_sync #(.W(6)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async({i_start_bit, i_mode_select_one, i_mode_select_two,
              i_spec_system_select, i_rot_dir, i_alarm_clear}),
    .o_sync(bits_sync)
  );

  assign {s_start, s_md1, s_md2, s_spec, s_dir, s_aclr} = bits_sync;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic logic [2:0] tbl_index(input logic [15:0] w);
    if (w >= 16'h0001 && w <= 16'h0008) begin
      tbl_index = 3'(w - 16'h0001);
    end else begin
      tbl_index = TBL_FIRST;
    end
  endfunction : tbl_index

  isp_state_t state;
  isp_state_t next_state;
  logic start_q;
  logic start_rise;
  logic opsel_ok;
  logic mode_ok;
  logic direct_ok;
  logic over_range;
  logic home_block;
  logic launch;
  logic done_now;
  logic [2:0] rd_idx;
  isp_entry_t entry;
  isp_cmd_t next_cmd;

  assign start_rise = s_start & ~start_q;
  assign opsel_ok = i_operation_select_param[OPSEL_MSB:OPSEL_LSB]
                    == OPSEL_INDEXER;
  // Mode select two set, mode select one clear, with register-specified station and speed
  assign mode_ok = opsel_ok & ~s_md1 & s_md2 & s_spec;
  // Direct speed falls back to table use without two stations
  assign direct_ok = i_speed_method_param & i_two_stations;
  assign over_range = i_next_station_word >= i_station_count_param;
  assign home_block = start_rise & mode_ok & ~i_home_done;
  // Busy start is dropped, not queued
  assign launch = start_rise & mode_ok & (state == ST_IDLE)
                  & i_home_done & ~over_range;
  assign done_now = (state == ST_MOVE) & i_move_done;
  assign next_state = launch ? ST_MOVE : (done_now ? ST_IDLE : state);

  // Direct speed reads entry 1 for its ramps
  assign rd_idx = direct_ok ? TBL_FIRST
                  : tbl_index(i_speed_or_table_word);

  isp_point_table #(.DEPTH(TBL_DEPTH)) u_tbl (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_we(i_tbl_we),
    .i_widx(i_tbl_idx),
    .i_wdata(i_tbl_data),
    .i_ridx(rd_idx),
    .o_rdata(entry)
  );

  assign next_cmd.station = i_next_station_word;
  assign next_cmd.speed = direct_ok ? i_speed_or_table_word
                          : entry.speed;
  assign next_cmd.acc_ms = entry.acc_ms;
  assign next_cmd.dec_ms = entry.dec_ms;
  assign next_cmd.dir = s_dir ^ i_station_direction_param;

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      start_q <= 1'b0;
      o_move_req <= 1'b0;
    end else begin
      state <= next_state;
      start_q <= s_start;
      o_move_req <= launch;
    end
  end

  // Command is frozen for the whole move
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_cmd <= '0;
    end else if (launch) begin
      o_cmd <= next_cmd;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_movement_complete_out <= 1'b0;
      o_station_out <= RST_STATION;
    end else if (launch) begin
      o_movement_complete_out <= 1'b0;
    end else if (done_now) begin
      o_movement_complete_out <= 1'b1;
      o_station_out <= o_cmd.station[7:0];
    end
  end

  // Range is checked from reset on, so power-up shows it too
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_in_position_out <= 1'b0;
    end else begin
      o_in_position_out <= (next_state == ST_IDLE) & i_in_range;
    end
  end

  // ---------------------------------------------------------------
  // Alarm and warning
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_home_incomplete_alarm <= 1'b0;
    end else if (home_block) begin
      o_home_incomplete_alarm <= 1'b1;
    end else if (s_aclr) begin
      o_home_incomplete_alarm <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_next_station_warning <= 1'b0;
    end else begin
      o_next_station_warning <= mode_ok & over_range;
    end
  end

  // ---------------------------------------------------------------
  // Torque limit switch-over
  // ---------------------------------------------------------------
  logic [31:0] pre_cnt;
  logic [15:0] ms_cnt;
  logic ms_tick;
  logic delay_met;

  assign ms_tick = pre_cnt == P_MS_CYC - 1;
  assign delay_met = ms_cnt >= i_torque_switch_delay_param;
  assign o_torque_limit = o_torque_sel ? i_positioning_torque_limit_param
                          : i_normal_torque_limit;

  // Prescaler restarts whenever in-position drops
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !o_in_position_out) begin
      pre_cnt <= '0;
      ms_cnt <= RST_WORD;
      o_torque_sel <= 1'b0;
    end else if (delay_met) begin
      o_torque_sel <= 1'b1;
    end else if (ms_tick) begin
      pre_cnt <= '0;
      ms_cnt <= ms_cnt + 16'h0001;
    end else begin
      pre_cnt <= pre_cnt + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_launch;
    launch ##1 (state == ST_MOVE && o_move_req);
  endsequence

  sequence s_finish;
    (state == ST_MOVE && i_move_done) ##1 o_movement_complete_out;
  endsequence

  chk_start_station: assert property (
    launch |=> o_cmd.station == $past(i_next_station_word))
    else $error("target station not taken from word");

  chk_table_speed: assert property (
    launch && !direct_ok |=> o_cmd.speed == $past(entry.speed)
      && $past(rd_idx) == $past(tbl_index(i_speed_or_table_word)))
    else $error("table speed not used");

  chk_direct_speed: assert property (
    launch && direct_ok |=> o_cmd.speed == $past(i_speed_or_table_word)
      && $past(rd_idx) == TBL_FIRST)
    else $error("direct speed or entry 1 ramps not used");

  chk_opsel_gate: assert property (
    start_rise && !opsel_ok |=> !o_move_req && !o_home_incomplete_alarm
      || $past(o_home_incomplete_alarm))
    else $error("start acted without indexer selection");

  chk_home_alarm: assert property (
    home_block |=> o_home_incomplete_alarm && !o_move_req)
    else $error("home alarm missing or move started");

  chk_busy_ignore: assert property (
    state == ST_MOVE && !i_move_done |=> state == ST_MOVE
      && $stable(o_cmd) && !o_move_req)
    else $error("start accepted during a move");

  chk_launch_status: assert property (
    s_launch |-> !o_movement_complete_out && !o_in_position_out)
    else $error("status not cleared at move start");

  chk_station_out: assert property (
    s_finish |-> o_station_out == $past(o_cmd.station[7:0]))
    else $error("station output not updated at completion");

  chk_warning: assert property (
    mode_ok && over_range |=> o_next_station_warning ##0 !o_move_req)
    else $error("station over range not flagged");

  chk_inpos_idle: assert property (
    state == ST_IDLE && !launch |=>
      o_in_position_out == $past(i_in_range))
    else $error("in-position does not follow range when idle");

  chk_torque_zero: assert property (
    o_in_position_out && !o_torque_sel
      && i_torque_switch_delay_param == RST_WORD
      |=> o_torque_sel || !o_in_position_out)
    else $error("torque limit not switched with zero delay");

  chk_torque_off: assert property (
    !o_in_position_out |=> !o_torque_sel
      && o_torque_limit == i_normal_torque_limit)
    else $error("positioning torque limit outside in-position");

endmodule : isp_indexer

/* bench/isp_motion_model.sv */
// Purpose: Stand-in for the motion loop that executes o_cmd
// Assumes: Same clock as the indexer; one move at a time
// Notes: Move time is set by the bench so moves can be long or short
module isp_motion_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Command handshake
  input wire logic i_move_req,
  input wire logic [7:0] i_delay,
  output logic o_move_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic [7:0] left;

  // Done is a single pulse, so a stuck move never reports twice
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      busy <= 1'b0;
      left <= 8'h00;
      o_move_done <= 1'b0;
    end else begin
      o_move_done <= busy && (left == 8'h00);
      if (i_move_req) begin
        busy <= 1'b1;
        left <= i_delay;
      end else if (busy && left == 8'h00) begin
        busy <= 1'b0;
      end else if (left != 8'h00) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule : isp_motion_model

/* bench/testbench.sv */
// Purpose: Self-checking bench of the indexer station positioner
// Assumes: P_MS_CYC shortened to 4 cycles per ms
// Notes: Inputs change and outputs are sampled at the falling edge
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import isp_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 0, rst = 1, start = 0, ms1 = 0, ms2 = 1, sss = 1;
  logic rdir = 0, aclr = 0, home = 0, inr = 1, smeth = 0, sdir = 1;
  logic two = 1, twe = 0, mdone, mreq, inpos, mcomp, halarm, nwarn, tsel;
  logic [15:0] nsw = 16'h0000, sw = 16'h0001, opsel = 16'h1000;
  logic [15:0] cnt = 16'h000A, ptl = 16'h0055, ntl = 16'h00AA;
  logic [15:0] dly = 16'h0002, tlim;
  logic [2:0] tidx = 3'h0;
  logic [7:0] sout;
  isp_entry_t tdat = '0;
  isp_cmd_t cmd;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, n;
  logic got;

  always #20 clk = ~clk;

  isp_indexer #(.P_MS_CYC(4)) u_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_start_bit(start),
    .i_mode_select_one(ms1), .i_mode_select_two(ms2),
    .i_spec_system_select(sss), .i_rot_dir(rdir), .i_alarm_clear(aclr),
    .i_next_station_word(nsw), .i_speed_or_table_word(sw),
    .i_operation_select_param(opsel), .i_speed_method_param(smeth),
    .i_station_direction_param(sdir), .i_station_count_param(cnt),
    .i_positioning_torque_limit_param(ptl), .i_normal_torque_limit(ntl),
    .i_torque_switch_delay_param(dly), .i_two_stations(two),
    .i_tbl_we(twe), .i_tbl_idx(tidx), .i_tbl_data(tdat),
    .i_home_done(home), .i_in_range(inr), .i_move_done(mdone),
    .o_move_req(mreq), .o_cmd(cmd), .o_in_position_out(inpos),
    .o_movement_complete_out(mcomp), .o_station_out(sout),
    .o_home_incomplete_alarm(halarm), .o_next_station_warning(nwarn),
    .o_torque_sel(tsel), .o_torque_limit(tlim)
  );

  isp_motion_model u_motion (
    .i_sys_clk(clk), .i_rst(rst), .i_move_req(mreq),
    .i_delay(8'h14), .o_move_done(mdone)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Pulse start and report whether a move request followed
  task automatic go(output logic seen);
    seen = 0;
    @(negedge clk) start = 1;
    repeat (6) begin
      @(negedge clk);
      if (mreq === 1'b1) seen = 1;
    end
    start = 0;
  endtask : go

  task automatic fin;
    n = 0;
    while (mcomp !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk("complete", 1, mcomp);
  endtask : fin

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_home;
    go(got);
    chk("move unhomed", 0, got);
    chk("home alarm", 1, halarm);
    aclr = 1;
    repeat (4) @(negedge clk);
    aclr = 0;
    home = 1;
    chk("alarm clear", 0, halarm);
    $display("test home done");
  endtask : t_home

  task automatic t_table(input logic [15:0] w);
    nsw = w + 16'h0001;
    sw = w;
    rdir = (w == 16'h0008);
    @(negedge clk);
    go(got);
    chk("move", 1, got);
    chk("station", w + 16'h0001, cmd.station);
    chk("speed", 16'h00FF + w, cmd.speed);
    chk("acc", (w == 1) ? TC_MAX_MS : 16'h000F + w, cmd.acc_ms);
    chk("dec", 16'h001F + w, cmd.dec_ms);
    chk("dir", {15'h0, ~rdir}, cmd.dir);
    chk("busy complete", 0, mcomp);
    sw = 16'h0003;
    go(got);
    chk("start in move", 0, got);
    chk("latched speed", 16'h00FF + w, cmd.speed);
    fin;
    chk("station out", w + 16'h0001, sout);
    chk("in position", 1, inpos);
    n = 0;
    while (tsel !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("torque delay", 1, n >= 7 && n <= 10);
    chk("torque limit", ptl, tlim);
    $display("test table %0d done", w);
  endtask : t_table

  task automatic t_direct;
    smeth = 1;
    dly = 16'h0000;
    sw = 16'h0ABC;
    go(got);
    chk("direct speed", 16'h0ABC, cmd.speed);
    chk("direct acc", TC_MAX_MS, cmd.acc_ms);
    chk("direct dec", 16'h0020, cmd.dec_ms);
    chk("torque normal", ntl, tlim);
    fin;
    repeat (2) @(negedge clk);
    chk("torque zero delay", 1, tsel);
    dly = 16'h0002;
    smeth = 0;
    $display("test direct done");
  endtask : t_direct

  task automatic t_refuse;
    nsw = cnt;
    repeat (4) @(negedge clk);
    chk("warning", 1, nwarn);
    go(got);
    chk("move over range", 0, got);
    nsw = cnt - 16'h0001;
    repeat (2) @(negedge clk);
    chk("no warning", 0, nwarn);
    opsel = 16'h2000;
    go(got);
    chk("mode off", 0, got);
    opsel = 16'h1000;
    ms1 = 1;
    go(got);
    chk("wrong mode", 0, got);
    ms1 = 0;
    inr = 0;
    repeat (3) @(negedge clk);
    chk("out of range", 0, inpos);
    inr = 1;
    two = 0;
    smeth = 1;
    sw = 16'h0002;
    go(got);
    chk("fallback move", 1, got);
    chk("fallback speed", 16'h0101, cmd.speed);
    fin;
    two = 1;
    smeth = 0;
    $display("test refuse done");
  endtask : t_refuse

  // ---------------------------------------------------------------
  // Main sequence and timeout
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim;
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk) rst = 0;
    repeat (3) @(negedge clk);
    chk("power in position", 1, inpos);
    chk("reset limit", ntl, tlim);
    for (int i = 0; i < 8; i++) begin
      tidx = i[2:0];
      tdat = '{16'h0100 + i, (i == 0) ? 16'hFFFF : 16'h0010 + i,
               16'h0020 + i};
      @(negedge clk) twe = 1;
      @(negedge clk) twe = 0;
    end
    t_home();
    t_table(16'h0001);
    t_table(16'h0008);
    t_direct();
    t_refuse();
    end_sim;
  end
endmodule : testbench
